// >>> cid_consts.svh
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH

// ****************************************
// program space and reset values
// ****************************************
`define CID_PC_W 12
`define CID_PC_RESET 12'h000
`define CID_ACC_RESET 8'h00
`define CID_BYTE_RESET 8'h00

// ****************************************
// data space addresses
// ****************************************
`define CID_PTR_X_ADDR 8'h80
`define CID_PTR_Y_ADDR 8'h81
`define CID_SHORT_BASE 6'h20

// ****************************************
// instruction lengths and cycle counts
// ****************************************
`define CID_LEN_1 2'h1
`define CID_LEN_2 2'h2
`define CID_LEN_3 2'h3
`define CID_CYC_2 3'h2
`define CID_CYC_4 3'h4
`define CID_CYC_5 3'h5

// ****************************************
// branch offsets and stack
// ****************************************
`define CID_REL_FWD_BIAS 12'h001
`define CID_BT_BIAS 12'h002
`define CID_STACK_DEPTH 3'h6
`define CID_STACK_PTR_RESET 3'h0

`endif

// >>> cid_pkg.sv
package cid_pkg;

  // ****************************************
  // operation kinds and operand sources
  // ****************************************
  typedef enum logic [4:0] {
    K_IDLE, K_MOVE_LOAD, K_MOVE_STORE, K_MOVE_IMM_A, K_MOVE_IMM_MEM, K_ZERO_MEM,
    K_ZERO_A, K_SUM, K_CONJ, K_COMPARE, K_DIFF, K_PLUS_ONE, K_MINUS_ONE,
    K_INVERT, K_ROTATE, K_SHIFT, K_BRANCH_REL, K_BIT_TEST, K_BIT_FORCE,
    K_CALL, K_JUMP, K_SUB_EXIT, K_INT_EXIT, K_HALT, K_IDLE_INT
  } cid_kind_t;

  typedef enum logic [2:0] {
    S_NONE, S_SHORT, S_DIRECT, S_IND, S_IMM, S_ACC
  } cid_src_t;

  typedef struct packed {
    cid_kind_t kind;
    cid_src_t src;
    logic [1:0] len;
    logic [2:0] cyc;
  } cid_dec_t;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    CID_ST_RUN = 3'b001,
    CID_ST_WAIT = 3'b010,
    CID_ST_HALT = 3'b100
  } cid_state_t;

endpackage

// >>> cid_ret_stack.sv
`timescale 1ns/1ps
`default_nettype none
`include "cid_consts.svh"

module cid_ret_stack (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // stack control
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] push_data,
  output logic [11:0] top_data
);

  logic [11:0] mem [0:5];
  logic [2:0] sp_reg;
  logic full;
  logic [2:0] top_idx;

  assign full = (sp_reg == `CID_STACK_DEPTH);
  assign top_idx = sp_reg - 3'h1;

  // ****************************************
  // pointer: pushes beyond depth are dropped
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sp_reg <= `CID_STACK_PTR_RESET;
    end else if (push && !full) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (pop && sp_reg != 3'h0) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !full) begin
      mem[sp_reg] <= push_data;
    end
  end

  // ****************************************
  // registered top of stack
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      top_data <= 12'h000;
    end else if (sp_reg != 3'h0) begin
      top_data <= mem[top_idx];
    end else begin
      top_data <= 12'h000;
    end
  end

endmodule // cid_ret_stack

`default_nettype wire

// >>> cid_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "cid_consts.svh"

module cid_decoder (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // program memory
  output logic [11:0] PROG_ADDR,
  input wire logic [7:0] PROG_DATA,
  // data space
  output logic [7:0] DATA_ADDR,
  output logic [7:0] DATA_WDATA,
  output logic DATA_WE,
  input wire logic [7:0] DATA_RDATA,
  // core control
  input wire logic WDOG_SEL,
  input wire logic WAKE,
  input wire logic RESTORE_ZERO,
  input wire logic RESTORE_CARRY,
  // status
  output logic [7:0] ACCUM,
  output logic ZERO_FLAG,
  output logic CARRY_FLAG,
  output logic [1:0] INSTR_LEN,
  output logic [2:0] INSTR_CYCLES,
  output logic WAIT_STATE,
  output logic HALT_STATE
);

  // ****************************************
  // decode functions
  // ****************************************
  function automatic cid_pkg::cid_dec_t mk(input cid_pkg::cid_kind_t k,
      input cid_pkg::cid_src_t s, input logic [1:0] l, input logic [2:0] c);
    cid_pkg::cid_dec_t d;
    d.kind = k;
    d.src = s;
    d.len = l;
    d.cyc = c;
    return d;
  endfunction

  function automatic cid_pkg::cid_kind_t alu_kind(input logic [2:0] code);
    case (code)
      3'h0: return cid_pkg::K_MOVE_LOAD;
      3'h1: return cid_pkg::K_COMPARE;
      3'h2: return cid_pkg::K_SUM;
      3'h3: return cid_pkg::K_PLUS_ONE;
      3'h4: return cid_pkg::K_MOVE_STORE;
      3'h5: return cid_pkg::K_CONJ;
      3'h6: return cid_pkg::K_DIFF;
      default: return cid_pkg::K_MINUS_ONE;
    endcase
  endfunction

  function automatic logic [2:0] bit_index(input logic [7:0] op);
    return {op[5], op[6], op[7]};
  endfunction

  // full opcode map: every byte value decodes to one kind
  function automatic cid_pkg::cid_dec_t decode(input logic [7:0] op);
    cid_pkg::cid_dec_t idle;
    idle = mk(cid_pkg::K_IDLE, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
    if (op[0] == 1'b0) begin
      return mk(cid_pkg::K_BRANCH_REL, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
    end
    case (op[3:0])
      4'h1: return mk(cid_pkg::K_CALL, cid_pkg::S_NONE, `CID_LEN_2, `CID_CYC_4);
      4'h9: return mk(cid_pkg::K_JUMP, cid_pkg::S_NONE, `CID_LEN_2, `CID_CYC_4);
      4'h3: return mk(cid_pkg::K_BIT_TEST, cid_pkg::S_DIRECT, `CID_LEN_3, `CID_CYC_5);
      4'hB: return mk(cid_pkg::K_BIT_FORCE, cid_pkg::S_DIRECT, `CID_LEN_2, `CID_CYC_4);
      4'h7: return mk(alu_kind(op[7:5]), cid_pkg::S_IND, `CID_LEN_1, `CID_CYC_4);
      4'h5: begin
        if (op[4]) begin
          return mk(op[5] ? cid_pkg::K_MOVE_LOAD : cid_pkg::K_PLUS_ONE, cid_pkg::S_SHORT,
              `CID_LEN_1, `CID_CYC_4);
        end
        case (op[7:5])
          3'h0: return mk(cid_pkg::K_INVERT, cid_pkg::S_ACC, `CID_LEN_1, `CID_CYC_4);
          3'h1: return mk(cid_pkg::K_ROTATE, cid_pkg::S_ACC, `CID_LEN_1, `CID_CYC_4);
          3'h2: return mk(cid_pkg::K_SHIFT, cid_pkg::S_ACC, `CID_LEN_2, `CID_CYC_4);
          3'h3: return mk(cid_pkg::K_ZERO_A, cid_pkg::S_ACC, `CID_LEN_2, `CID_CYC_4);
          3'h5: return mk(cid_pkg::K_SUB_EXIT, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
          3'h6: return mk(cid_pkg::K_IDLE_INT, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
          default: return idle;
        endcase
      end
      4'hD: begin
        if (op[4]) begin
          return mk(op[5] ? cid_pkg::K_MOVE_STORE : cid_pkg::K_MINUS_ONE, cid_pkg::S_SHORT,
              `CID_LEN_1, `CID_CYC_4);
        end
        case (op[7:5])
          3'h0: return mk(cid_pkg::K_MOVE_IMM_MEM, cid_pkg::S_DIRECT, `CID_LEN_3, `CID_CYC_4);
          3'h1: return mk(cid_pkg::K_ZERO_MEM, cid_pkg::S_DIRECT, `CID_LEN_3, `CID_CYC_4);
          3'h2: return mk(cid_pkg::K_INT_EXIT, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
          3'h3: return mk(cid_pkg::K_HALT, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
          3'h4: return mk(cid_pkg::K_PLUS_ONE, cid_pkg::S_ACC, `CID_LEN_2, `CID_CYC_4);
          3'h5: return mk(cid_pkg::K_MINUS_ONE, cid_pkg::S_ACC, `CID_LEN_2, `CID_CYC_4);
          default: return idle;
        endcase
      end
      4'hF: begin
        if (!op[4]) begin
          return mk(alu_kind(op[7:5]), cid_pkg::S_DIRECT, `CID_LEN_2, `CID_CYC_4);
        end
        case (op[7:5])
          3'h0: return mk(cid_pkg::K_MOVE_IMM_A, cid_pkg::S_IMM, `CID_LEN_2, `CID_CYC_4);
          3'h1, 3'h2, 3'h5, 3'h6: return mk(alu_kind(op[7:5]), cid_pkg::S_IMM,
              `CID_LEN_2, `CID_CYC_4);
          default: return idle;
        endcase
      end
      default: return idle;
    endcase
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  cid_pkg::cid_state_t state_reg;
  cid_pkg::cid_dec_t dec_reg;
  cid_pkg::cid_dec_t dec_now;
  logic [2:0] phase_reg;
  logic [7:0] op_reg, byte2_reg, byte3_reg, addr_reg, acc_reg;
  logic [11:0] pc_reg, inst_pc_reg, stack_top;
  logic zero_reg, carry_reg, last, exec, run;

  assign dec_now = decode(PROG_DATA);
  assign run = (state_reg == cid_pkg::CID_ST_RUN);
  assign last = (phase_reg != 3'h0) && (phase_reg == dec_reg.cyc - 3'h1);
  assign exec = run && last;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= cid_pkg::CID_ST_RUN;
    end else begin
      case (state_reg)
        cid_pkg::CID_ST_RUN: begin
          if (exec && dec_reg.kind == cid_pkg::K_IDLE_INT) begin
            state_reg <= cid_pkg::CID_ST_WAIT;
          end else if (exec && dec_reg.kind == cid_pkg::K_HALT) begin
            state_reg <= WDOG_SEL ? cid_pkg::CID_ST_WAIT : cid_pkg::CID_ST_HALT;
          end
        end
        cid_pkg::CID_ST_WAIT, cid_pkg::CID_ST_HALT: begin
          if (WAKE) begin
            state_reg <= cid_pkg::CID_ST_RUN;
          end
        end
        default: state_reg <= cid_pkg::CID_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      phase_reg <= 3'h0;
    end else if (!run || last) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end

  // opcode, operand bytes and reported length/cycles
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      op_reg <= `CID_BYTE_RESET;
      byte2_reg <= `CID_BYTE_RESET;
      byte3_reg <= `CID_BYTE_RESET;
      dec_reg <= mk(cid_pkg::K_IDLE, cid_pkg::S_NONE, `CID_LEN_1, `CID_CYC_2);
      inst_pc_reg <= `CID_PC_RESET;
    end else if (run && phase_reg == 3'h0) begin
      op_reg <= PROG_DATA;
      dec_reg <= dec_now;
      inst_pc_reg <= pc_reg;
    end else if (run && phase_reg == 3'h1 && dec_reg.len != `CID_LEN_1) begin
      byte2_reg <= PROG_DATA;
    end else if (run && phase_reg == 3'h2 && dec_reg.len == `CID_LEN_3) begin
      byte3_reg <= PROG_DATA;
    end
  end

  // ****************************************
  // branch targets
  // ****************************************
  logic [11:0] rel_target, bt_target, ext_target;
  logic rel_cond, tested_bit;

  always_comb begin
    rel_target = op_reg[3] ? inst_pc_reg - {8'h00, op_reg[7:4]}
        : inst_pc_reg + {8'h00, op_reg[7:4]} + `CID_REL_FWD_BIAS;
    bt_target = inst_pc_reg + `CID_BT_BIAS + {{4{byte3_reg[7]}}, byte3_reg};
    ext_target = {op_reg[7:4], byte2_reg};
    case (op_reg[2:1])
      2'h0: rel_cond = !zero_reg;
      2'h1: rel_cond = !carry_reg;
      2'h2: rel_cond = zero_reg;
      default: rel_cond = carry_reg;
    endcase
    tested_bit = DATA_RDATA[bit_index(op_reg)];
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pc_reg <= `CID_PC_RESET;
    end else if (exec) begin
      case (dec_reg.kind)
        cid_pkg::K_BRANCH_REL: if (rel_cond) pc_reg <= rel_target;
        cid_pkg::K_BIT_TEST: begin
          if (tested_bit == op_reg[4]) begin
            pc_reg <= bt_target;
          end
        end
        cid_pkg::K_CALL, cid_pkg::K_JUMP: pc_reg <= ext_target;
        cid_pkg::K_SUB_EXIT, cid_pkg::K_INT_EXIT: pc_reg <= stack_top;
        default: pc_reg <= pc_reg;
      endcase
    end else if (run && (phase_reg == 3'h0 || (phase_reg == 3'h1 && dec_reg.len != `CID_LEN_1)
        || (phase_reg == 3'h2 && dec_reg.len == `CID_LEN_3))) begin
      pc_reg <= pc_reg + 12'h001;
    end
  end

  cid_ret_stack u_stack (
    .clk(SYS_CLK),
    .nrst(NRST),
    .push(exec && dec_reg.kind == cid_pkg::K_CALL),
    .pop(exec && (dec_reg.kind == cid_pkg::K_SUB_EXIT || dec_reg.kind == cid_pkg::K_INT_EXIT)),
    .push_data(pc_reg),
    .top_data(stack_top)
  );

  // ****************************************
  // data space address
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      addr_reg <= `CID_BYTE_RESET;
    end else if (run && phase_reg == 3'h0 && dec_now.src == cid_pkg::S_SHORT) begin
      addr_reg <= {`CID_SHORT_BASE, PROG_DATA[7], PROG_DATA[6]};
    end else if (run && phase_reg == 3'h0 && dec_now.src == cid_pkg::S_IND) begin
      addr_reg <= PROG_DATA[4] ? `CID_PTR_Y_ADDR : `CID_PTR_X_ADDR;
    end else if (run && phase_reg == 3'h1 && dec_reg.src == cid_pkg::S_DIRECT) begin
      addr_reg <= PROG_DATA;
    end else if (run && phase_reg == 3'h2 && dec_reg.src == cid_pkg::S_IND) begin
      addr_reg <= DATA_RDATA;
    end
  end

  // ****************************************
  // execute
  // ****************************************
  logic [7:0] opnd, res;
  logic [8:0] sum9, diff9;
  logic acc_we, mem_we, z_we, c_we, c_val;

  always_comb begin
    opnd = (dec_reg.src == cid_pkg::S_IMM) ? byte2_reg
        : (dec_reg.src == cid_pkg::S_ACC) ? acc_reg : DATA_RDATA;
    sum9 = {1'b0, acc_reg} + {1'b0, opnd};
    diff9 = {1'b0, acc_reg} - {1'b0, opnd};
    res = opnd;
    acc_we = 1'b0;
    mem_we = 1'b0;
    z_we = 1'b0;
    c_we = 1'b0;
    c_val = carry_reg;
    case (dec_reg.kind)
      cid_pkg::K_MOVE_LOAD, cid_pkg::K_MOVE_IMM_A: begin
        acc_we = 1'b1;
        z_we = 1'b1;
      end
      cid_pkg::K_MOVE_STORE: begin
        res = acc_reg;
        mem_we = 1'b1;
        z_we = 1'b1;
      end
      cid_pkg::K_MOVE_IMM_MEM: begin
        res = byte3_reg;
        mem_we = 1'b1;
      end
      cid_pkg::K_ZERO_MEM: begin
        res = 8'h00;
        mem_we = 1'b1;
      end
      cid_pkg::K_ZERO_A: begin
        res = 8'h00;
        acc_we = 1'b1;
        z_we = 1'b1;
        c_we = 1'b1;
        c_val = 1'b0;
      end
      cid_pkg::K_SUM, cid_pkg::K_DIFF, cid_pkg::K_COMPARE, cid_pkg::K_CONJ: begin
        res = (dec_reg.kind == cid_pkg::K_SUM) ? sum9[7:0]
            : (dec_reg.kind == cid_pkg::K_CONJ) ? (acc_reg & opnd) : diff9[7:0];
        acc_we = (dec_reg.kind != cid_pkg::K_COMPARE);
        z_we = 1'b1;
        c_we = 1'b1;
        c_val = (dec_reg.kind == cid_pkg::K_SUM) ? sum9[8]
            : (dec_reg.kind == cid_pkg::K_CONJ) ? 1'b0 : diff9[8];
      end
      cid_pkg::K_PLUS_ONE, cid_pkg::K_MINUS_ONE: begin
        res = (dec_reg.kind == cid_pkg::K_PLUS_ONE) ? opnd + 8'h01 : opnd - 8'h01;
        acc_we = (dec_reg.src == cid_pkg::S_ACC);
        mem_we = (dec_reg.src != cid_pkg::S_ACC);
        z_we = 1'b1;
      end
      cid_pkg::K_INVERT, cid_pkg::K_ROTATE, cid_pkg::K_SHIFT: begin
        res = (dec_reg.kind == cid_pkg::K_INVERT) ? ~acc_reg
            : {acc_reg[6:0], (dec_reg.kind == cid_pkg::K_ROTATE) ? carry_reg : 1'b0};
        acc_we = 1'b1;
        z_we = 1'b1;
        c_we = 1'b1;
        c_val = acc_reg[7];
      end
      cid_pkg::K_BIT_TEST: begin
        c_we = 1'b1;
        c_val = tested_bit;
      end
      cid_pkg::K_BIT_FORCE: begin
        res = DATA_RDATA;
        res[bit_index(op_reg)] = op_reg[4];
        mem_we = 1'b1;
      end
      default: res = opnd;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      acc_reg <= `CID_ACC_RESET;
    end else if (exec && acc_we) begin
      acc_reg <= res;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      zero_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else if (exec && dec_reg.kind == cid_pkg::K_INT_EXIT) begin
      zero_reg <= RESTORE_ZERO;
      carry_reg <= RESTORE_CARRY;
    end else if (exec) begin
      if (z_we) zero_reg <= (res == 8'h00);
      if (c_we) carry_reg <= c_val;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      DATA_WE <= 1'b0;
      DATA_WDATA <= `CID_BYTE_RESET;
    end else begin
      DATA_WE <= exec && mem_we;
      if (exec && mem_we) DATA_WDATA <= res;
    end
  end

  assign PROG_ADDR = pc_reg;
  assign DATA_ADDR = addr_reg;
  assign ACCUM = acc_reg;
  assign ZERO_FLAG = zero_reg;
  assign CARRY_FLAG = carry_reg;
  assign INSTR_LEN = dec_reg.len;
  assign INSTR_CYCLES = dec_reg.cyc;
  assign WAIT_STATE = (state_reg == cid_pkg::CID_ST_WAIT);
  assign HALT_STATE = (state_reg == cid_pkg::CID_ST_HALT);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_rel_two_cycles: assert property (run && phase_reg == 3'h0 && dec_now.kind == cid_pkg::K_BRANCH_REL
      |-> ##2 phase_reg == 3'h0 && $stable(ZERO_FLAG)) else $error("relative branch length");
  a_rel_target: assert property (exec && dec_reg.kind == cid_pkg::K_BRANCH_REL && rel_cond
      |=> pc_reg == $past(rel_target)) else $error("relative branch target");
  a_bit_test_len: assert property (run && phase_reg == 3'h0 && dec_now.kind == cid_pkg::K_BIT_TEST
      |-> ##5 phase_reg == 3'h0 && pc_reg != $past(pc_reg, 5)) else $error("bit test length");
  a_bit_to_carry: assert property (exec && dec_reg.kind == cid_pkg::K_BIT_TEST
      |=> carry_reg == $past(tested_bit) && $stable(zero_reg)) else $error("bit test carry");
  a_move_keeps_carry: assert property (exec && dec_reg.kind inside {cid_pkg::K_MOVE_LOAD,
      cid_pkg::K_MOVE_STORE, cid_pkg::K_PLUS_ONE, cid_pkg::K_MINUS_ONE}
      |=> $stable(carry_reg)) else $error("carry changed by move");
  a_imm_store: assert property (exec && dec_reg.kind == cid_pkg::K_MOVE_IMM_MEM
      |=> DATA_WE && DATA_WDATA == byte3_reg && $stable(zero_reg) && $stable(carry_reg))
      else $error("immediate store");
  a_halt_as_wait: assert property (exec && dec_reg.kind == cid_pkg::K_HALT && WDOG_SEL
      |=> WAIT_STATE && !HALT_STATE) else $error("halt not replaced");
  a_jump_target: assert property (exec && dec_reg.kind == cid_pkg::K_JUMP
      |=> pc_reg == {$past(op_reg[7:4]), $past(byte2_reg)}) else $error("jump target");
  a_pc_advance: assert property (run && phase_reg == 3'h0
      |=> pc_reg == $past(pc_reg) + 12'h001 && INSTR_LEN == $past(dec_now.len))
      else $error("fetch advance");
  a_unknown_idle: assert property (run && phase_reg == 3'h0 && dec_now.kind == cid_pkg::K_IDLE
      |-> ##2 $stable(acc_reg) && phase_reg == 3'h0) else $error("undefined opcode");
  a_zero_fill_acc: assert property (exec && dec_reg.kind == cid_pkg::K_ZERO_A
      |=> acc_reg == 8'h00 && zero_reg && !carry_reg) else $error("accumulator clear");

  c_bit_branch: cover property (exec && dec_reg.kind == cid_pkg::K_BIT_TEST && tested_bit == op_reg[4]);
  c_call: cover property (exec && dec_reg.kind == cid_pkg::K_CALL);
  c_wake: cover property (WAIT_STATE ##1 run);

endmodule // cid_decoder

`default_nettype wire

// >>> cid_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module cid_mem_model (
  // clock
  input wire logic clk,
  // program memory
  input wire logic [11:0] prog_addr,
  output logic [7:0] prog_data,
  // data space
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  output logic [7:0] data_rdata
);
  logic [7:0] prog_mem [0:4095];
  logic [7:0] data_mem [0:255];

  // reads answer in the same cycle as the address
  assign prog_data = prog_mem[prog_addr];
  assign data_rdata = data_mem[data_addr];

  always @(posedge clk) begin
    if (data_we) begin
      data_mem[data_addr] <= data_wdata;
    end
  end
endmodule // cid_mem_model

`default_nettype wire

// >>> cid_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module cid_decoder_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wdog_sel = 1'b0;
  logic wake = 1'b0;
  logic restore_zero = 1'b1;
  logic restore_carry = 1'b0;
  logic [11:0] prog_addr;
  logic [7:0] prog_data, data_addr, data_wdata, data_rdata, accum;
  logic data_we, zero_flag, carry_flag, wait_state, halt_state;
  logic [1:0] instr_len;
  logic [2:0] instr_cycles;
  int miscompares = 0;
  int n_compared = 0;

  always #25 sys_clk = ~sys_clk;

  cid_decoder i_cid_decoder (.SYS_CLK(sys_clk), .NRST(nrst), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .DATA_ADDR(data_addr), .DATA_WDATA(data_wdata),
    .DATA_WE(data_we), .DATA_RDATA(data_rdata), .WDOG_SEL(wdog_sel), .WAKE(wake),
    .RESTORE_ZERO(restore_zero), .RESTORE_CARRY(restore_carry), .ACCUM(accum), .ZERO_FLAG(zero_flag),
    .CARRY_FLAG(carry_flag), .INSTR_LEN(instr_len), .INSTR_CYCLES(instr_cycles),
    .WAIT_STATE(wait_state), .HALT_STATE(halt_state));

  cid_mem_model i_cid_mem_model (.clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
    .data_rdata(data_rdata));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ****************************************
  // program load and reset
  // ****************************************
  task automatic load(input logic [47:0] code);
    for (int i = 0; i < 4096; i++) i_cid_mem_model.prog_mem[i] = 8'h85;
    for (int i = 0; i < 6; i++) i_cid_mem_model.prog_mem[i] = code[47-8*i -: 8];
    nrst = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 nrst = 1'b1;
  endtask

  // runs the opcode at p until the phase returns to 0, then checks the fetch address against nxt
  task automatic run(input string name, input logic [47:0] code, input logic [11:0] p,
      input logic [11:0] nxt, input logic [4:0] lc, input logic [7:0] a, input logic [1:0] zc);
    int n;
    logic [4:0] lc_seen;
    load(code);
    n = 0;
    // operand fetches move the address ahead of execute: wait for the opcode fetch itself
    while ((prog_addr !== p || i_cid_decoder.phase_reg !== 3'h0) && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
      if (n == 1) lc_seen = {instr_len, instr_cycles};
    end while (i_cid_decoder.phase_reg !== 3'h0 && n < 40);
    check({name, " cycles"}, 16'(n), 16'(lc[2:0]));
    check({name, " next"}, 16'(prog_addr), 16'(nxt));
    check({name, " len cyc"}, 16'(lc_seen), 16'(lc));
    check({name, " acc flags"}, 16'({accum, zero_flag, carry_flag}), 16'({a, zc}));
    $display("done %s", name);
  endtask

  task automatic halt_case(input logic wd);
    wdog_sel = wd;
    load(48'h6D85_8585_8585);
    repeat (4) @(posedge sys_clk);
    #1 check("wait state", 16'(wait_state), 16'(wd));
    check("halt state", 16'(halt_state), 16'(!wd));
    wake = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check("woken", 16'({wait_state, halt_state}), 16'h0000);
    wake = 1'b0;
    wdog_sel = 1'b0;
    $display("done halt %0d", wd);
  endtask

  task automatic final_report;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    run("imm load", 48'h1F00_8585_8585, 12'h000, 12'h002, {2'h2, 3'h4}, 8'h00, 2'h2);
    run("sum carry", 48'h1FFF_5F01_8585, 12'h002, 12'h004, {2'h2, 3'h4}, 8'h00, 2'h3);
    run("br carry", 48'h1FFF_5F01_3685, 12'h004, 12'h008, {2'h1, 3'h2}, 8'h00, 2'h3);
    run("br back", 48'h1F05_2885_8585, 12'h002, 12'h000, {2'h1, 3'h2}, 8'h05, 2'h0);
    run("bit high", 48'h0D40_0113_40FD, 12'h003, 12'h002, {2'h3, 3'h5}, 8'h00, 2'h1);
    run("bit low", 48'h0D40_0103_4010, 12'h003, 12'h006, {2'h3, 3'h5}, 8'h00, 2'h1);
    run("jump", 48'hA934_8585_8585, 12'h000, 12'hA34, {2'h2, 3'h4}, 8'h00, 2'h0);
    run("invert", 48'h1F80_0585_8585, 12'h002, 12'h003, {2'h1, 3'h4}, 8'h7F, 2'h1);
    run("undefined", 48'h1F05_ED85_8585, 12'h002, 12'h003, {2'h1, 3'h2}, 8'h05, 2'h0);
    run("int exit", 48'h0104_8585_4D85, 12'h004, 12'h002, {2'h1, 3'h2}, 8'h00, 2'h2);
    run("store ind", 48'h1F77_0D80_3087, 12'h005, 12'h006, {2'h1, 3'h4}, 8'h77, 2'h0);
    check("store addr", 16'({data_we, data_addr}), 16'h0130);
    check("store data", 16'(data_wdata), 16'h0077);
    repeat (2) @(posedge sys_clk);
    #1 check("ind byte", 16'(i_cid_mem_model.data_mem[8'h30]), 16'h0077);
    halt_case(1'b0);
    halt_case(1'b1);
    final_report();
  end

  initial begin
    #(3000 * 50);
    miscompares++;
    final_report();
  end
endmodule // cid_decoder_tb_top

`default_nettype wire
